// [bench/rsi_board.sv]
`timescale 1ns/1ps
// ********************************************************************
// Board side: reset source, strap resistors and the shared pin.
// ********************************************************************
module rsi_board (
  input  wire logic       clk,           // System clock.
  input  wire logic       rst_go,        // Request for one reset pulse.
  input  wire logic [2:0] cfg_lvl,       // Config select strap levels.
  input  wire logic [1:0] fix_lvl,       // Fixed-port strap levels.
  input  wire logic       ind_pin_out,   // Device drive level.
  input  wire logic       ind_pin_oe_n,  // Device enable, low drives.
  output logic            reset_pin_n,   // Board reset, active low.
  output logic            cfg_hi_pin,    // Upper select pin.
  output logic            cfg_mid_pin,   // Middle select pin.
  output logic            cfg_lo_pin,    // Lower select pin.
  output logic            fixed_hi_pin,  // Upper fixed strap pin.
  output logic            ind_pin_in     // Shared pin level.
);
  localparam int LOW_CYC = 100;  // One microsecond of low reset at 100 MHz.
  int            cnt = 0;        // Remaining low cycles of the pulse.

  // Once asked, hold reset low for the full pulse width.
  always @(posedge clk) begin
    if (rst_go) begin
      cnt <= LOW_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign reset_pin_n  = (cnt == 0);
  assign cfg_hi_pin   = cfg_lvl[2];
  assign cfg_mid_pin  = cfg_lvl[1];
  assign cfg_lo_pin   = cfg_lvl[0];
  assign fixed_hi_pin = fix_lvl[1];
  // The device drive wins; when released the strap resistor sets the level.
  assign ind_pin_in   = ind_pin_oe_n ? fix_lvl[0] : ind_pin_out;
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
`include "rsi_defines.svh"
// ********************************************************************
// Self-checking bench for the strap and indicator block.
// ********************************************************************
module tb;
  import rsi_pkg::*;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp=%0h got=%0h", nm, (e), (g)); end end
  logic        clk = 1'h0;        // System clock.
  logic        sys_rst = 1'h1;    // Synchronous reset.
  logic        rst_go = 1'h0;     // Board reset request.
  logic [2:0]  cfg_lvl = 3'h0;    // Config strap levels.
  logic [1:0]  fix_lvl = 2'h0;    // Fixed strap levels.
  logic        psel = 1'h0;       // APB select.
  logic        penable = 1'h0;    // APB enable.
  logic        pwrite = 1'h0;     // APB direction.
  logic [11:0] paddr = 12'h000;   // APB address.
  logic [31:0] pwdata = 32'h0;    // APB write data.
  logic [7:0]  rnd = 8'h13;       // Random state.
  int          err_count = 0;     // Mismatches.
  int          comparisons = 0;   // Checks made.
  int          mask_tab[4] = '{0, 1, 3, 7};  // Fixed ports per strap value.
  wire         reset_pin_n, cfg_hi_pin, cfg_mid_pin, cfg_lo_pin, fixed_hi_pin, ind_pin_in;
  wire         ind_pin_out, ind_pin_oe_n, hub_rst, self_power, pready, pslverr;
  wire [2:0]   cfg_code, fixed_ports;
  wire [31:0]  prdata;

  // Free-running 100 MHz clock; the bench drives it straight to both the board and the block.
  always #5 clk = ~clk;

  rsi_board brd (.clk(clk), .rst_go(rst_go), .cfg_lvl(cfg_lvl), .fix_lvl(fix_lvl),
    .ind_pin_out(ind_pin_out), .ind_pin_oe_n(ind_pin_oe_n), .reset_pin_n(reset_pin_n),
    .cfg_hi_pin(cfg_hi_pin), .cfg_mid_pin(cfg_mid_pin), .cfg_lo_pin(cfg_lo_pin),
    .fixed_hi_pin(fixed_hi_pin), .ind_pin_in(ind_pin_in));

  rsi_top dut (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .cfg_hi_pin(cfg_hi_pin),
    .cfg_mid_pin(cfg_mid_pin), .cfg_lo_pin(cfg_lo_pin), .fixed_hi_pin(fixed_hi_pin),
    .ind_pin_in(ind_pin_in), .ind_pin_out(ind_pin_out), .ind_pin_oe_n(ind_pin_oe_n),
    .hub_rst(hub_rst), .cfg_code(cfg_code), .fixed_ports(fixed_ports), .self_power(self_power),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Eight-bit feedback shift register for the strap levels.
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout();
    err_count++;
    $display("[FAIL] wait exp=done got=timeout");
    wrap_up();
  endtask

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (k == 20) timeout();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  // Board reset pulse; the control word is written while the hub is held.
  task automatic pin_reset(input logic [31:0] ctrl);
    int          k;
    logic [31:0] rd;
    logic        er;
    rst_go <= 1'h1;
    @(posedge clk);
    rst_go <= 1'h0;
    for (k = 0; k < 20 && hub_rst !== 1'h1; k++) @(posedge clk);
    if (k == 20) timeout();
    apb(1'h1, `RSI_CTRL_OFF, ctrl, rd, er);
    for (k = 0; k < 200 && hub_rst !== 1'h0; k++) @(posedge clk);
    if (k == 200) timeout();
    repeat (2) @(posedge clk);
  endtask

  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    int          i;
    int          j;
    int          k;
    logic [2:0]  code;
    logic [1:0]  fx;
    logic [2:0]  msk;
    logic        en;
    logic        act;
    logic [31:0] rd;
    logic        er;
    repeat (6) @(posedge clk);
    `CHK("oe_n_in_reset", 1'h1, ind_pin_oe_n)
    sys_rst <= 1'h0;
    for (k = 0; k < 1200 && hub_rst !== 1'h0; k++) @(posedge clk);
    `CHK("por_hold", 1'h1, k >= 1000 && k < 1200)
    apb(1'h0, `RSI_CTRL_OFF, 32'h0, rd, er);
    `CHK("ctrl_reset", 32'h4, rd)
    // Every code, with and without the upper select pin, random fixed straps.
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      cfg_lvl <= i[2:0];
      fix_lvl <= rnd[1:0];
      pin_reset({29'h0, i[3], 2'h0});
      code = {i[2] & i[3], i[1:0]};
      en = (code == 3'h0) || (code == 3'h2);
      fx = en ? rnd[1:0] : 2'h0;
      msk = 3'(mask_tab[fx]);
      // Pins change after release; the latched values must not.
      cfg_lvl <= ~cfg_lvl;
      fix_lvl <= ~fix_lvl;
      repeat (10) @(posedge clk);
      `CHK("cfg_code", code, cfg_code)
      `CHK("fixed_ports", msk, fixed_ports)
      `CHK("self_power", rnd[0], self_power)
      for (j = 0; j < 4; j++) begin
        apb(1'h1, `RSI_CTRL_OFF, {29'h0, i[3], j[1:0]}, rd, er);
        act = j[0] & ~j[1];
        apb(1'h0, `RSI_STAT_OFF, 32'h0, rd, er);
        `CHK("status", {19'h0, msk, act, 1'h0, fx[0], rnd[0], fx, en, code}, rd)
        `CHK("ind_out", act ^ fx[0], ind_pin_out)
        `CHK("ind_oe_n", 1'h0, ind_pin_oe_n)
      end
    end
    apb(1'h1, 12'h008, 32'hFFFFFFFF, rd, er);
    `CHK("unmapped_wr_err", 1'h1, er)
    apb(1'h0, 12'h008, 32'h0, rd, er);
    `CHK("unmapped_rd", 33'h100000000, {er, rd})
    apb(1'h0, `RSI_CTRL_OFF, 32'h0, rd, er);
    `CHK("ctrl_readback", 32'h7, rd)
    wrap_up();
  end
endmodule

// [rtl/rsi_defines.svh]
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH

// ********************************************************************
// Register map of the APB slave.
// ********************************************************************
`define RSI_CTRL_OFF       12'h000
`define RSI_STAT_OFF       12'h004

// ********************************************************************
// Control register fields and reset values.
// ********************************************************************
`define RSI_CTRL_CONF_BIT  0
`define RSI_CTRL_SUSP_BIT  1
`define RSI_CTRL_HIPR_BIT  2
`define RSI_CTRL_CONF_RST  1'h0
`define RSI_CTRL_SUSP_RST  1'h0
`define RSI_CTRL_HIPR_RST  1'h1

// ********************************************************************
// Status register fields.
// ********************************************************************
`define RSI_STAT_CODE_LSB  0
`define RSI_STAT_EN_BIT    3
`define RSI_STAT_FIX_LSB   4
`define RSI_STAT_PWR_BIT   6
`define RSI_STAT_POL_BIT   7
`define RSI_STAT_RST_BIT   8
`define RSI_STAT_IND_BIT   9
`define RSI_STAT_MASK_LSB  10

// ********************************************************************
// Configuration codes that leave the straps enabled.
// ********************************************************************
`define RSI_CODE_DEF       3'h0
`define RSI_CODE_DEF_BUS   3'h2

// ********************************************************************
// Timing: clock period and internal power-on hold time.
// ********************************************************************
`define RSI_CLK_PERIOD_NS  10
`define RSI_POR_TIME_NS    10000
`define RSI_POR_CYCLES     ((`RSI_POR_TIME_NS + `RSI_CLK_PERIOD_NS - 1) / `RSI_CLK_PERIOD_NS)

`endif

// [rtl/rsi_pkg.sv]
// ********************************************************************
// Types shared by the strap and indicator block.
// ********************************************************************
package rsi_pkg;

  // Sequencer states: power-on hold, pin reset hold, running.
  typedef enum logic [1:0] {RSI_POR, RSI_HOLD, RSI_RUN} rsi_state_e;

  // State of the two-stage synchroniser.
  typedef struct packed {
    logic [5:0] ff1;  // First stage, read only by the second.
    logic [5:0] ff2;  // Second stage, safe for logic.
  } rsi_sync_s;

  // Whole state of the top module.
  typedef struct packed {
    rsi_state_e  st;          // Sequencer state.
    logic [9:0]  por_cnt;     // Power-on hold counter.
    logic [2:0]  code;        // Latched configuration code.
    logic        strap_en;    // Straps enabled by the code.
    logic [1:0]  fixed;       // Latched fixed-port strap.
    logic [2:0]  fixed_mask;  // Fixed ports 3 to 1.
    logic        self_pwr;    // Latched self-power level.
    logic        configured;  // Hub configured, from software.
    logic        suspend;     // Hub suspended, from software.
    logic        hi_present;  // Upper select pin bonded out.
    logic        hub_rst;     // Internal hub reset.
    logic        ind_out;     // Indicator pin output level.
    logic        ind_oe_n;    // Indicator pin enable, low drives.
    logic        pready;      // APB ready.
    logic        pslverr;     // APB error.
    logic [31:0] prdata;      // APB read data.
  } rsi_top_s;

endpackage

// [rtl/rsi_sync.sv]
`timescale 1ns/1ps
// ********************************************************************
// Two-flop synchroniser for the six pin inputs.
// ********************************************************************
module rsi_sync
  import rsi_pkg::*;
(
  input  wire logic       clk,      // System clock.
  input  wire logic       sys_rst,  // Synchronous reset, active high.
  input  wire logic [5:0] d_in,     // Asynchronous pin levels.
  output logic [5:0]      d_out     // Synchronised levels.
);

  rsi_sync_s s_r;    // Registered state.
  rsi_sync_s s_nxt;  // Next state.

  // Shifts the pins through both stages.
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = d_in;
    s_nxt.ff2 = s_r.ff1;
  end

  // Registers the state; resets to all ones like an idle pulled-up pin.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '{ff1: 6'h3F, ff2: 6'h3F};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign d_out = s_r.ff2;

endmodule

// [rtl/rsi_top.sv]
`timescale 1ns/1ps
`include "rsi_defines.svh"
// What this block does
// R1 - Latch upper config select at reset release.
// R2 - Missing upper select pin reads as zero.
// R3 - Board holds reset low at least 1 us.
// R4 - Internal power-on reset when pin tied high.
// R5 - Board supplies the 24 MHz clock. Here the bench supplies a 100 MHz clock.
// R6 - Indicator asserted only configured and active.
// R7 - Local power pin high means self-power.
// R8 - Sample both fixed-port straps at release.
// R9 - Fixed strap picks ports and LED polarity.
// R10 - Latch lower config selects at release too.
// R11 - Straps honoured only for enabling codes.
// R12 - Latched straps hold until next reset.
// R13 - Indicator uses strap-selected polarity after release.
module rsi_top
  import rsi_pkg::*;
(
  input  wire logic        clk,           // System clock, 100 MHz.
  input  wire logic        sys_rst,       // Synchronous reset, active high.
  input  wire logic        reset_pin_n,   // Board reset pin, active low.
  input  wire logic        cfg_hi_pin,    // Upper config select pin.
  input  wire logic        cfg_mid_pin,   // Middle config select pin.
  input  wire logic        cfg_lo_pin,    // Lower config select pin.
  input  wire logic        fixed_hi_pin,  // Upper fixed-port strap pin.
  input  wire logic        ind_pin_in,    // Indicator pin level as read.
  output logic             ind_pin_out,   // Indicator pin drive level.
  output logic             ind_pin_oe_n,  // Indicator pin enable, low drives.
  output logic             hub_rst,       // Internal hub reset.
  output logic [2:0]       cfg_code,      // Latched configuration code.
  output logic [2:0]       fixed_ports,   // Fixed ports 3 to 1.
  output logic             self_power,    // Self-power available.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic [31:0]      prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr        // APB error.
);

  // ******************************************************************
  // Constants and state.
  // ******************************************************************
  localparam logic [9:0] POR_LAST = 10'(`RSI_POR_CYCLES - 1);  // Last hold count.

  localparam rsi_top_s RST_V = '{
    st: RSI_POR, por_cnt: 10'h000, code: 3'h0, strap_en: 1'h0, fixed: 2'h0,
    fixed_mask: 3'h0, self_pwr: 1'h0, configured: `RSI_CTRL_CONF_RST,
    suspend: `RSI_CTRL_SUSP_RST, hi_present: `RSI_CTRL_HIPR_RST,
    hub_rst: 1'h1, ind_out: 1'h0, ind_oe_n: 1'h1, pready: 1'h0,
    pslverr: 1'h0, prdata: 32'h0000_0000};

  rsi_top_s   s_r;        // Registered state.
  rsi_top_s   s_nxt;      // Next state.
  logic [5:0] pins_s;     // Synchronised pins.
  logic       rst_pin_s;  // Synchronised reset pin.
  logic [2:0] cap_code;   // Code seen on the pins now.
  logic       cap_en;     // Straps enabled by that code.
  logic [1:0] cap_fixed;  // Fixed strap seen now, or zero.
  logic       ind_act;    // Indicator should be asserted.
  logic       led_low;    // LED is active low.
  logic       acc;        // APB access phase.
  logic       map_hit;    // Address is mapped.

  // ******************************************************************
  // Pin synchroniser.
  // ******************************************************************
  rsi_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_in    ({reset_pin_n, cfg_hi_pin, cfg_mid_pin, cfg_lo_pin, fixed_hi_pin, ind_pin_in}),
    .d_out   (pins_s)
  );

  // ******************************************************************
  // Capture values and indicator decode.
  // ******************************************************************
  assign rst_pin_s = pins_s[5];
  // The upper select counts as low when the pin is not bonded out.
  assign cap_code  = {pins_s[4] & s_r.hi_present, pins_s[3], pins_s[2]};  // R1 R2 R10
  assign cap_en    = (cap_code == `RSI_CODE_DEF) || (cap_code == `RSI_CODE_DEF_BUS);  // R11
  // Both strap bits are taken in the same cycle.
  assign cap_fixed = cap_en ? {pins_s[1], pins_s[0]} : 2'h0;  // R8 R11
  assign ind_act   = s_r.configured & ~s_r.suspend;  // R6
  assign led_low   = s_r.fixed[0];  // R9 R13
  assign acc       = psel & penable;
  assign map_hit   = (paddr == `RSI_CTRL_OFF) || (paddr == `RSI_STAT_OFF);

  // Maps the fixed strap to a port mask.
  function automatic logic [2:0] fix_mask(input logic [1:0] f);
    logic [2:0] m;
    m = 3'h0;
    unique case (f)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;  // R9
  endfunction

  // ******************************************************************
  // Next-state logic: reset sequencer, indicator and APB slave.
  // ******************************************************************
  always_comb begin
    s_nxt = s_r;
    // Reset sequencer.
    unique case (s_r.st)
      RSI_POR: begin
        // Holds the hub in reset and the indicator pin released for the power-on time.
        s_nxt.hub_rst  = 1'h1;
        s_nxt.ind_oe_n = 1'h1;
        if (s_r.por_cnt == POR_LAST) begin
          s_nxt.st = RSI_HOLD;  // R4
        end else begin
          s_nxt.por_cnt = s_r.por_cnt + 10'h001;
        end
      end
      RSI_HOLD: begin
        // Pin released: latch every strap once and start running.
        s_nxt.hub_rst  = 1'h1;
        s_nxt.ind_oe_n = 1'h1;
        if (rst_pin_s) begin
          s_nxt.st         = RSI_RUN;
          s_nxt.hub_rst    = 1'h0;
          s_nxt.code       = cap_code;  // R1 R10
          s_nxt.strap_en   = cap_en;  // R11
          s_nxt.fixed      = cap_fixed;  // R8
          s_nxt.fixed_mask = fix_mask(cap_fixed);  // R9
          s_nxt.self_pwr   = pins_s[0];  // R7
        end
      end
      RSI_RUN: begin
        if (!rst_pin_s) begin
          // Pin asserted again: release the pin for fresh straps.
          s_nxt.st       = RSI_HOLD;
          s_nxt.hub_rst  = 1'h1;
          s_nxt.ind_oe_n = 1'h1;
          s_nxt.ind_out  = 1'h0;
        end else begin
          // Latched values are left alone while running.
          s_nxt.ind_oe_n = 1'h0;  // R12
          s_nxt.ind_out  = ind_act ^ led_low;  // R6 R13
        end
      end
      default: begin
        // An unused state code returns to the power-on state without clearing the hold counter.
        s_nxt.st = RSI_POR;
      end
    endcase
    // APB slave: one wait state, then the transfer completes.
    if (acc && !s_r.pready) begin
      s_nxt.pready  = 1'h1;
      s_nxt.pslverr = ~map_hit;
      s_nxt.prdata  = 32'h0000_0000;
      if (!pwrite && paddr == `RSI_CTRL_OFF) begin
        s_nxt.prdata[`RSI_CTRL_CONF_BIT] = s_r.configured;
        s_nxt.prdata[`RSI_CTRL_SUSP_BIT] = s_r.suspend;
        s_nxt.prdata[`RSI_CTRL_HIPR_BIT] = s_r.hi_present;
      end else if (!pwrite && paddr == `RSI_STAT_OFF) begin
        s_nxt.prdata[`RSI_STAT_CODE_LSB +: 3] = s_r.code;
        s_nxt.prdata[`RSI_STAT_EN_BIT]        = s_r.strap_en;
        s_nxt.prdata[`RSI_STAT_FIX_LSB +: 2]  = s_r.fixed;
        s_nxt.prdata[`RSI_STAT_PWR_BIT]       = s_r.self_pwr;
        s_nxt.prdata[`RSI_STAT_POL_BIT]       = led_low;
        s_nxt.prdata[`RSI_STAT_RST_BIT]       = s_r.hub_rst;
        s_nxt.prdata[`RSI_STAT_IND_BIT]       = ind_act;
        s_nxt.prdata[`RSI_STAT_MASK_LSB +: 3] = s_r.fixed_mask;
      end
    end else if (acc && s_r.pready) begin
      // Completing edge: the write takes effect here and only here.
      s_nxt.pready  = 1'h0;
      s_nxt.pslverr = 1'h0;
      if (pwrite && paddr == `RSI_CTRL_OFF) begin
        s_nxt.configured = pwdata[`RSI_CTRL_CONF_BIT];
        s_nxt.suspend    = pwdata[`RSI_CTRL_SUSP_BIT];
        s_nxt.hi_present = pwdata[`RSI_CTRL_HIPR_BIT];
      end
    end else begin
      s_nxt.pready  = 1'h0;
      s_nxt.pslverr = 1'h0;
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= RST_V;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************************************************
  // Outputs, all straight from the state register.
  // ******************************************************************
  assign ind_pin_out  = s_r.ind_out;
  assign ind_pin_oe_n = s_r.ind_oe_n;
  assign hub_rst      = s_r.hub_rst;
  assign cfg_code     = s_r.code;
  assign fixed_ports  = s_r.fixed_mask;
  assign self_power   = s_r.self_pwr;
  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;

  // ******************************************************************
  // Assertions and covers.
  // ******************************************************************
  // Entering run latches the code seen on the pins one cycle before.
  property p_cap_code;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_RUN && $past(s_r.st) == RSI_HOLD) |-> cfg_code == $past(cap_code);
  endproperty
  a_cap_code: assert property (p_cap_code) else $error("Code not latched at release."); // R1

  // Without the upper pin the upper bit is always zero.
  property p_hi_absent;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_HOLD && rst_pin_s && !s_r.hi_present) |=> cfg_code[2] == 1'b0;
  endproperty
  a_hi_absent: assert property (p_hi_absent) else $error("Absent upper select read high."); // R2

  // Internal reset stays on through the whole power-on hold.
  property p_por_hold;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_POR) |-> (hub_rst && ind_pin_oe_n);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("Reset released during power-on hold."); // R4

  // A negated indicator drives the inactive level of the polarity.
  property p_ind_neg;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_RUN && rst_pin_s && !ind_act) |=> (!ind_pin_oe_n && ind_pin_out == $past(led_low));
  endproperty
  a_ind_neg: assert property (p_ind_neg) else $error("Indicator asserted while inactive."); // R6

  // Self power follows the pin level sampled at release.
  property p_self_pwr;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_HOLD && rst_pin_s) |=> self_power == $past(pins_s[0]);
  endproperty
  a_self_pwr: assert property (p_self_pwr) else $error("Self power not taken at release."); // R7

  // Disabled straps give no fixed ports and an active-high LED.
  property p_strap_off;
    @(posedge clk) disable iff (sys_rst)
    (!s_r.strap_en) |-> (fixed_ports == 3'h0 && !led_low);
  endproperty
  a_strap_off: assert property (p_strap_off) else $error("Straps used while disabled."); // R11

  // Fixed-port mask matches the two strap bits.
  property p_mask;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_RUN) |-> fixed_ports == ((s_r.fixed == 2'h3) ? 3'h7 : (s_r.fixed == 2'h2) ? 3'h3 :
                                            (s_r.fixed == 2'h1) ? 3'h1 : 3'h0);
  endproperty
  a_mask: assert property (p_mask) else $error("Fixed port mask wrong."); // R9

  // Latched values do not move while running.
  property p_hold;
    @(posedge clk) disable iff (sys_rst)
    (s_r.st == RSI_RUN && $past(s_r.st) == RSI_RUN) |-> ($stable(cfg_code) && $stable(fixed_ports) && $stable(self_power));
  endproperty
  a_hold: assert property (p_hold) else $error("Latched strap changed while running."); // R12

  // The APB slave answers exactly one cycle into the access phase.
  property p_apb_wait;
    @(posedge clk) disable iff (sys_rst)
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB ready timing wrong.");

  c_strap_on: cover property (@(posedge clk) disable iff (sys_rst) s_r.st == RSI_RUN && s_r.strap_en);
  c_strap_lo: cover property (@(posedge clk) disable iff (sys_rst) s_r.st == RSI_RUN && led_low && ind_act);
  c_rerst:    cover property (@(posedge clk) disable iff (sys_rst) s_r.st == RSI_RUN ##1 s_r.st == RSI_HOLD);

endmodule
